// file: verilog/line_status_defines.svh
// line status block: offsets, field positions, reset values, timing counts
// assumes a 25 MHz hclk and a 32-bit ahb-lite register bus
//
// Functional notes
// - fifo data error set by any error tag
// - error flag clears when no tagged characters remain
// - non-fifo: empty when holding and shift empty
// - empty flag low while any character pending
// - fifo: empty when tx fifo and shift empty
// - non-fifo: holding empty set on move to shift
// - holding empty cleared on cpu character write
// - holding empty raises interrupt when enabled
// - fifo: holding empty follows tx fifo emptiness
// - break flag set after full low frame
// - one break character per break condition
// - bit 3 shows framing error, reset zero
// - framing error refers to fifo top character
`ifndef LINE_STATUS_DEFINES_SVH
`define LINE_STATUS_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define LS_OFF_STATUS   8'h00
`define LS_OFF_CONTROL  8'h04
`define LS_OFF_EVENTS   8'h08
`define LS_OFF_MASK     8'h0c

// ************************************************************
// line status bit positions
// ************************************************************
`define LS_BIT_DATA_ERR 7
`define LS_BIT_TX_EMPTY 6
`define LS_BIT_HOLD_EMP 5
`define LS_BIT_BREAK    4
`define LS_BIT_FRAME    3

// ************************************************************
// control bits and reset values
// ************************************************************
`define LS_CTL_FIFO_MODE 0
`define LS_CTL_HOLD_IE   1
`define LS_CTL_RESET     2'h0
`define LS_MASK_RESET    4'h0

// ************************************************************
// timing: bit time in hclk cycles, bits in one frame
// ************************************************************
`define LS_BIT_DIV      16'd217
`define LS_FRAME_BITS   8'd10
`define LS_FIFO_DEPTH   128

`endif

// file: verilog/line_status_pkg.sv
// types shared by the line status block
// assumes nothing beyond the defines header
package line_status_pkg;
  // per character receive tags: parity, framing, break
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
  } rx_tag_s;
  // event status bit index
  typedef enum logic [1:0] {
    ev_data_err = 2'h0,
    ev_break    = 2'h1,
    ev_frame    = 2'h3,
    ev_hold     = 2'h2
  } event_e;
endpackage : line_status_pkg

// file: verilog/tag_memory.sv
// small memory holding the error tags of the receive fifo entries
// assumes one write and one read per cycle on one clock
`timescale 1ns/1ps
module tag_memory #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 3,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  // storage array, no reset needed
  logic [WIDTH-1:0] mem [DEPTH];
  // write port
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read, new data passed through on address match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= '0;
    end else if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : tag_memory

// file: verilog/break_detect.sv
// detects a receive line held low for a whole frame
// assumes rx_level is already synchronised to hclk
`timescale 1ns/1ps
`include "line_status_defines.svh"
module break_detect #(
  parameter logic [15:0] BIT_DIV    = `LS_BIT_DIV,
  parameter logic [7:0]  FRAME_BITS = `LS_FRAME_BITS
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic rx_level,
  output logic      break_pulse
);
  logic [15:0] div_cnt;   // bit time divider
  logic        bit_tick;  // one cycle per bit time
  logic [7:0]  low_bits;  // whole bits seen low
  logic        reported;  // break already pushed

  assign bit_tick = (div_cnt == BIT_DIV - 16'd1);

  // bit time divider, held at zero while the line is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 16'h0;
    end else if (bit_tick || rx_level) begin
      div_cnt <= 16'h0;
    end else begin
      div_cnt <= div_cnt + 16'd1;
    end
  end

  // count low bits, report once per low stretch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_bits    <= 8'h0;
      reported    <= 1'b0;
      break_pulse <= 1'b0;
    end else begin
      break_pulse <= 1'b0;
      if (rx_level) begin
        // line back high: rearm
        low_bits <= 8'h0;
        reported <= 1'b0;
      end else if (bit_tick && !reported) begin
        low_bits <= low_bits + 8'd1;
        if (low_bits + 8'd1 >= FRAME_BITS) begin
          break_pulse <= 1'b1;
          reported    <= 1'b1;
        end
      end
    end
  end
endmodule : break_detect

// file: verilog/line_status.sv
// line status upper bits with their receive tag fifo, on ahb-lite
// assumes transmitter and receiver logic share hclk; rx_in is a pin
`timescale 1ns/1ps
`include "line_status_defines.svh"
module line_status #(
  parameter int          DEPTH      = `LS_FIFO_DEPTH,
  parameter logic [15:0] BIT_DIV    = `LS_BIT_DIV,
  parameter logic [7:0]  FRAME_BITS = `LS_FRAME_BITS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_in,
  input  wire logic        rx_char_push,
  input  wire logic        rx_char_pe,
  input  wire logic        rx_char_fe,
  input  wire logic        rx_pop,
  input  wire logic        thr_load,
  input  wire logic        thr_to_tsr,
  input  wire logic        thr_full,
  input  wire logic        tx_fifo_empty,
  input  wire logic        tsr_empty,
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // bus address phase
  // ************************************************************
  logic        ph_valid;   // a transfer is taken this edge
  logic        ph_read;    // taken transfer is a read
  logic        ph_write;   // taken transfer is a write
  logic [7:0]  ph_off;     // word aligned byte offset
  logic        sel_status; // line status register selected
  logic        sel_ctl;    // control register selected
  logic        sel_evt;    // event status selected
  logic        sel_mask;   // event mask selected
  logic        wr_pend;    // write waiting for its data phase
  logic [7:0]  wr_off;     // offset of pending write

  assign ph_valid   = hsel && htrans[1] && hready;
  assign ph_read    = ph_valid && !hwrite;
  assign ph_write   = ph_valid && hwrite;
  assign ph_off     = {haddr[7:2], 2'b00};
  assign sel_status = ph_off == `LS_OFF_STATUS;
  assign sel_ctl    = ph_off == `LS_OFF_CONTROL;
  assign sel_evt    = ph_off == `LS_OFF_EVENTS;
  assign sel_mask   = ph_off == `LS_OFF_MASK;

  // ************************************************************
  // software registers
  // ************************************************************
  logic [1:0]  ctl;        // fifo mode, holding empty irq enable
  logic [3:0]  evt_mask;   // event interrupt mask
  logic        fifo_mode;  // fifo mode selected
  logic        hold_ie;    // holding empty interrupt enable
  logic        wr_ctl;     // control write in data phase
  logic        wr_mask;    // mask write in data phase

  assign fifo_mode = ctl[`LS_CTL_FIFO_MODE];
  assign hold_ie   = ctl[`LS_CTL_HOLD_IE];
  assign wr_ctl    = wr_pend && wr_off == `LS_OFF_CONTROL;
  assign wr_mask   = wr_pend && wr_off == `LS_OFF_MASK;

  // latch write address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_off  <= 8'h0;
    end else begin
      wr_pend <= ph_write;
      wr_off  <= ph_off;
    end
  end

  // control and mask take data; status offset has no write path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl      <= `LS_CTL_RESET;
      evt_mask <= `LS_MASK_RESET;
    end else begin
      if (wr_ctl) begin
        ctl <= hwdata[1:0];
      end
      if (wr_mask) begin
        evt_mask <= hwdata[3:0];
      end
    end
  end

  // ************************************************************
  // receive line synchroniser and break detector
  // ************************************************************
  logic rx_meta;     // first stage
  logic rx_sync;     // second stage, safe to use
  logic brk_pulse;   // one pulse per break condition

  // two stage synchroniser for the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_in;
      rx_sync <= rx_meta;
    end
  end

  // frame long low detector
  break_detect #(
    .BIT_DIV    (BIT_DIV),
    .FRAME_BITS (FRAME_BITS)
  ) u_break (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .rx_level    (rx_sync),
    .break_pulse (brk_pulse)
  );

  // ************************************************************
  // receive tag fifo
  // ************************************************************
  logic [AW-1:0] rd_ptr;      // head entry
  logic [AW-1:0] wr_ptr;      // next free entry
  logic [AW:0]   count;       // entries held
  logic [AW:0]   err_count;   // entries with any error tag
  logic          fifo_full;   // no room left
  logic          fifo_empty;  // nothing held
  logic          push;        // entry accepted
  logic          pop;         // head entry removed
  logic [2:0]    push_tag;    // tags of entry pushed
  logic [2:0]    top_tag;     // tags of head entry
  logic          push_err;    // pushed entry has an error
  logic          top_err;     // head entry has an error
  logic [AW-1:0] next_rd_ptr; // head after this edge
  line_status_pkg::rx_tag_s in_tag; // tag fields of incoming entry

  assign fifo_full   = count == DEPTH[AW:0];
  assign fifo_empty  = count == '0;
  assign in_tag.brk  = brk_pulse;
  assign in_tag.fe   = rx_char_fe && rx_char_push;
  assign in_tag.pe   = rx_char_pe && rx_char_push;
  assign push_tag    = in_tag;
  // a break pushes its own character, only one per condition
  assign push        = (rx_char_push || brk_pulse) && !fifo_full;
  assign pop         = rx_pop && !fifo_empty;
  assign push_err    = |push_tag;
  assign top_err     = |top_tag;
  assign next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;

  // tag storage with registered head read
  tag_memory #(
    .DEPTH (DEPTH),
    .WIDTH (3)
  ) u_tags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (push),
    .waddr   (wr_ptr),
    .wdata   (push_tag),
    .raddr   (next_rd_ptr),
    .rdata   (top_tag)
  );

  // pointers and occupancy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end

  // running count of tagged entries still held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_count <= '0;
    end else if (push && push_err && !(pop && top_err)) begin
      err_count <= err_count + (AW+1)'(1);
    end else if (pop && top_err && !(push && push_err)) begin
      err_count <= err_count - (AW+1)'(1);
    end
  end

  // ************************************************************
  // line status flags
  // ************************************************************
  logic data_err_flag;     // fifo data error
  logic tx_empty_flag;     // transmitter empty
  logic hold_empty_flag;   // holding register empty
  logic break_flag;        // break seen since last read
  logic frame_flag;        // head character framing error
  logic tx_fifo_empty_q;   // previous tx fifo empty level
  logic next_tx_empty;     // transmitter empty next value
  logic next_hold_empty;   // holding empty next value
  logic hold_set;          // event that sets holding empty
  logic rd_status;         // line status read this edge
  logic [7:0] status_word; // assembled status byte

  // fifo mode: both tx fifo and shift empty, else holding and shift
  assign next_tx_empty = fifo_mode ? (tx_fifo_empty && tsr_empty)
                                   : (!thr_full && tsr_empty);
  // fifo mode: set when tx fifo turns empty, else on move to shift
  assign hold_set = fifo_mode ? (tx_fifo_empty && !tx_fifo_empty_q)
                              : thr_to_tsr;
  // a cpu write clears, an arriving set wins
  assign next_hold_empty = hold_set ? 1'b1
                         : thr_load ? 1'b0
                         : hold_empty_flag;
  assign rd_status = ph_read && sel_status;

  // transmitter and holding register flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_flag   <= 1'b1;
      hold_empty_flag <= 1'b1;
      tx_fifo_empty_q <= 1'b1;
    end else begin
      tx_empty_flag   <= next_tx_empty;
      hold_empty_flag <= next_hold_empty;
      tx_fifo_empty_q <= tx_fifo_empty;
    end
  end

  // receive side flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_err_flag <= 1'b0;
      frame_flag    <= 1'b0;
      break_flag    <= 1'b0;
    end else begin
      // high while any tagged entry remains
      data_err_flag <= err_count != '0;
      // framing error of the current head entry
      frame_flag    <= (count != '0) && top_tag[1];
      // sticky until status read, new break wins
      if (brk_pulse) begin
        break_flag <= 1'b1;
      end else if (rd_status) begin
        break_flag <= 1'b0;
      end
    end
  end

  // bits 2..0 belong to other logic and read zero here
  assign status_word = {data_err_flag, tx_empty_flag, hold_empty_flag,
                        break_flag, frame_flag, 3'b000};

  // ************************************************************
  // event status and interrupt
  // ************************************************************
  logic [3:0] evt_status;  // sticky events, cleared by read
  logic [3:0] evt_set;     // events this cycle
  logic       rd_evt;      // event status read this edge
  logic       data_err_q;  // previous data error flag
  logic       frame_q;     // previous framing flag
  logic       hold_q;      // previous holding empty flag
  logic       next_irq;    // interrupt next value

  assign rd_evt = ph_read && sel_evt;
  assign evt_set[line_status_pkg::ev_data_err] = data_err_flag && !data_err_q;
  assign evt_set[line_status_pkg::ev_break]    = brk_pulse;
  assign evt_set[line_status_pkg::ev_hold]     = hold_empty_flag && !hold_q;
  assign evt_set[line_status_pkg::ev_frame]    = frame_flag && !frame_q;
  assign next_irq = (|(evt_status & evt_mask)) || (hold_empty_flag && hold_ie);

  // edge history for event detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_err_q <= 1'b0;
      frame_q    <= 1'b0;
      hold_q     <= 1'b1;
    end else begin
      data_err_q <= data_err_flag;
      frame_q    <= frame_flag;
      hold_q     <= hold_empty_flag;
    end
  end

  // per bit sticky status, set wins over read clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          evt_status[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_status[gi] <= 1'b1;
        end else if (rd_evt) begin
          evt_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt line from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ************************************************************
  // bus read data and response
  // ************************************************************
  logic [31:0] rd_mux;  // read data selected in address phase

  assign rd_mux = sel_status ? {24'h0, status_word}
                : sel_ctl    ? {30'h0, ctl}
                : sel_evt    ? {28'h0, evt_status}
                : sel_mask   ? {28'h0, evt_mask}
                : 32'h0;

  // zero wait state slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ph_read) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule : line_status

// file: dv/line_status_monitor.sv
// concurrent checks on the line status block, bound to its ports
// assumes one bus master and a shadow of control and mask kept here
`timescale 1ns/1ps
module line_status_monitor #(
  parameter int          DEPTH      = 128,
  parameter logic [15:0] BIT_DIV    = 16'd217,
  parameter logic [7:0]  FRAME_BITS = 8'd10
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        rx_in,
  input wire logic        rx_char_push,
  input wire logic        rx_char_pe,
  input wire logic        rx_char_fe,
  input wire logic        thr_load,
  input wire logic        thr_to_tsr,
  input wire logic        thr_full,
  input wire logic        tx_fifo_empty,
  input wire logic        tsr_empty
);
  // low cycles on the pin, sync stages included, before a break shows
  localparam int LIMIT = FRAME_BITS * BIT_DIV + 2;
  // ****
  // shadow of control and mask
  // ****
  logic        ap_wr;   // write address phase pending
  logic [7:0]  ap_addr; // its offset
  logic [1:0]  ctl_q;   // fifo mode, holding interrupt enable
  logic [3:0]  mask_q;  // event mask
  logic [15:0] low_cnt; // consecutive low cycles of rx_in
  wire         take    = hsel & htrans[1] & hready;
  wire         rd_take = take & !hwrite;
  wire         quiet   = !ctl_q[1] && mask_q == 4'h0;
  // follow writes into control and mask at their data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
      ctl_q   <= 2'h0;
      mask_q  <= 4'h0;
    end else begin
      ap_wr   <= take & hwrite;
      ap_addr <= haddr[7:0];
      if (ap_wr && ap_addr == 8'h04) begin
        ctl_q <= hwdata[1:0];
      end
      if (ap_wr && ap_addr == 8'h0c) begin
        mask_q <= hwdata[3:0];
      end
    end
  end
  // count how long the receive pin has stayed low, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 16'h0000;
    end else if (rx_in) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hffff) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // status read with mode and transmit levels settled
  sequence s_txe_rd;
    rd_take && haddr[7:2] == 6'h00 && $stable(ctl_q) && $stable(thr_full)
      && $stable(tx_fifo_empty) && $stable(tsr_empty);
  endsequence
  // cpu load in plain mode with nothing else able to raise irq
  sequence s_load;
    thr_load && !thr_to_tsr && ctl_q == 2'h2 && mask_q == 4'h0;
  endsequence
  chk_txe_plain: assert property (s_txe_rd ##0 !ctl_q[0] |=>
    hrdata[6] == $past(!thr_full & tsr_empty)) else $error("plain tx empty wrong");
  chk_txe_fifo: assert property (s_txe_rd ##0 ctl_q[0] |=>
    hrdata[6] == $past(tx_fifo_empty & tsr_empty)) else $error("fifo tx empty wrong");
  chk_hold_irq: assert property (thr_to_tsr && ctl_q == 2'h2 |-> ##2 irq)
    else $error("holding empty irq missing");
  chk_load_clears: assert property (s_load |-> ##2 !irq)
    else $error("holding empty not cleared by load");
  chk_irq_quiet: assert property ($past(quiet) |-> !irq)
    else $error("irq without enable");
  chk_break_irq: assert property (low_cnt == LIMIT && mask_q[1] |-> ##[1:10] irq)
    else $error("break event missing");
  chk_err_irq: assert property (rx_char_push && (rx_char_pe | rx_char_fe) && mask_q[0]
    |-> ##[1:6] irq) else $error("data error event missing");
  chk_frame_irq: assert property (rx_char_push && rx_char_fe && mask_q[3]
    |-> ##[1:6] irq) else $error("framing event missing");
  chk_unmapped_zero: assert property (rd_take && haddr[7:2] > 6'h03 |=>
    hrdata == 32'h0) else $error("unmapped read not zero");
endmodule : line_status_monitor

bind line_status line_status_monitor #(
  .DEPTH(DEPTH), .BIT_DIV(BIT_DIV), .FRAME_BITS(FRAME_BITS)
) line_status_monitor_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .irq(irq),
  .rx_in(rx_in), .rx_char_push(rx_char_push), .rx_char_pe(rx_char_pe),
  .rx_char_fe(rx_char_fe), .thr_load(thr_load), .thr_to_tsr(thr_to_tsr),
  .thr_full(thr_full), .tx_fifo_empty(tx_fifo_empty), .tsr_empty(tsr_empty)
);

// file: dv/host_cpu_model.sv
// host cpu model: single whole-word ahb-lite transfers
// assumes hready is the one slave's hreadyout
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // bus idle at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // one transfer: address phase held until ready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : host_cpu_model

// file: dv/tb_line_status.sv
// self-checking bench for the line status block
// assumes the host model drives the bus and the bench the tx/rx side
`timescale 1ns/1ps
`include "line_status_defines.svh"
module tb_line_status;
  logic        hclk;       // 25 mhz bus clock
  logic        hresetn;    // async reset
  logic        rx_pin;     // serial receive pin
  logic [3:0]  pul;        // push, pop, load, move strobes
  logic [4:0]  lv;         // pe, fe, hold full, fifo empty, shift empty
  wire         hsel;
  wire         hwrite;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire  [31:0] haddr;
  wire  [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;      // bus response, okay expected
  wire         irq;
  int          n_fail;
  int          cmp_count;
  // ****
  // clock, design and host
  // ****
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;
  line_status #(.DEPTH(4), .BIT_DIV(16'd4), .FRAME_BITS(8'd3)) line_status_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_pin),
    .rx_char_push(pul[0]), .rx_char_pe(lv[4]), .rx_char_fe(lv[3]), .rx_pop(pul[1]),
    .thr_load(pul[2]), .thr_to_tsr(pul[3]), .thr_full(lv[2]),
    .tx_fifo_empty(lv[1]), .tsr_empty(lv[0]), .irq(irq));
  host_cpu_model host_cpu_model_inst (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ****
  // shared tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    host_cpu_model_inst.xfer(1'b1, a, d, dummy);
  endtask : wr
  task check_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_cpu_model_inst.xfer(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask : check_reg
  task chk_irq(input logic e);
    // irq is a flop behind the registers: let one more edge pass
    @(posedge hclk);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq
  // one strobe cycle with new levels, then a settling gap
  task step(input logic [3:0] m, input logic [4:0] l);
    @(posedge hclk);
    pul <= m;
    lv  <= l;
    @(posedge hclk);
    pul <= 4'h0;
    repeat (4) @(posedge hclk);
  endtask : step
  // ****
  // scenarios
  // ****
  task t_reset;
    check_reg(`LS_OFF_STATUS, 32'h60);
    check_reg(`LS_OFF_CONTROL, 32'h0);
    check_reg(8'h10, 32'h0);
    wr(`LS_OFF_STATUS, 32'hff);
    chk({31'h0, hresp}, 32'h0);
    check_reg(`LS_OFF_STATUS, 32'h60);
  endtask : t_reset
  task t_tx_plain;
    wr(`LS_OFF_CONTROL, 32'h2);
    chk_irq(1'b1);
    step(4'h4, 5'b00101);
    check_reg(`LS_OFF_STATUS, 32'h00);
    chk_irq(1'b0);
    step(4'h8, 5'b00010);
    check_reg(`LS_OFF_STATUS, 32'h20);
    chk_irq(1'b1);
    step(4'h0, 5'b00011);
    check_reg(`LS_OFF_STATUS, 32'h60);
    wr(`LS_OFF_CONTROL, 32'h0);
  endtask : t_tx_plain
  task t_tx_fifo;
    wr(`LS_OFF_CONTROL, 32'h1);
    step(4'h4, 5'b00001);
    check_reg(`LS_OFF_STATUS, 32'h00);
    step(4'h0, 5'b00010);
    check_reg(`LS_OFF_STATUS, 32'h20);
    step(4'h0, 5'b00011);
    check_reg(`LS_OFF_STATUS, 32'h60);
    wr(`LS_OFF_CONTROL, 32'h0);
  endtask : t_tx_fifo
  task t_rx_err;
    logic [31:0] d;
    host_cpu_model_inst.xfer(1'b0, `LS_OFF_EVENTS, 32'h0, d);
    wr(`LS_OFF_MASK, 32'h9);
    step(4'h1, 5'b01011);
    check_reg(`LS_OFF_STATUS, 32'he8);
    chk_irq(1'b1);
    check_reg(`LS_OFF_EVENTS, 32'h09);
    chk_irq(1'b0);
    wr(`LS_OFF_MASK, 32'h0);
    step(4'h1, 5'b10011);
    step(4'h2, 5'b00011);
    check_reg(`LS_OFF_STATUS, 32'he0);
    step(4'h2, 5'b00011);
    check_reg(`LS_OFF_STATUS, 32'h60);
  endtask : t_rx_err
  task t_break;
    wr(`LS_OFF_MASK, 32'h2);
    @(posedge hclk);
    rx_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    rx_pin <= 1'b1;
    check_reg(`LS_OFF_STATUS, 32'h60);
    @(posedge hclk);
    rx_pin <= 1'b0;
    repeat (60) @(posedge hclk);
    rx_pin <= 1'b1;
    chk_irq(1'b1);
    check_reg(`LS_OFF_STATUS, 32'hf0);
    check_reg(`LS_OFF_STATUS, 32'he0);
    step(4'h2, 5'b00011);
    check_reg(`LS_OFF_STATUS, 32'h60);
    check_reg(`LS_OFF_EVENTS, 32'h03);
    chk_irq(1'b0);
    wr(`LS_OFF_MASK, 32'h0);
  endtask : t_break
  // ****
  // verdict, main sequence, watchdog
  // ****
  task report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    n_fail    = 0;
    cmp_count = 0;
    hresetn   = 1'b0;
    rx_pin    = 1'b1;
    pul       = 4'h0;
    lv        = 5'b00011;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_tx_plain;
    t_tx_fifo;
    t_rx_err;
    t_break;
    report_and_stop;
  end
  // whole run is well under 2000 cycles
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
endmodule : tb_line_status
